// [verilog/sp_pkg.sv]
// Summary of operation
// - two mode bits pick sync or async framing
// - power control bit turns top bit into error flag
// - bad stop bit sets sticky frame error
// - modes 2/3 multiproc: ninth bit zero suppresses
// - mode 1 multiproc: bad stop suppresses receive flag
// - mode 0 multiproc bit picks divide 12 or 4
// - reception only while receive enable is set
// - modes 2/3 send software ninth bit
// - ninth bit or stop bit captured per mode
// - transmit flag timing per mode, software clears
// - receive flag timing per mode, software clears
// - buffer reads receive, writes transmit
// - software loads the slave match address
// - global gates the interrupt, serial enable gates only the flag source
// - mask bits choose compared address bits
package sp_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_BUFFER = 8'h99;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
   localparam logic [7:0] ADDR_SLAVE = 8'hA9;
   localparam logic [7:0] ADDR_MASK = 8'hB9;
   localparam logic [7:0] ADDR_POWER = 8'hC8;
   localparam logic [7:0] ADDR_STATUS = 8'hC9;
   localparam logic [7:0] ADDR_STAT_MASK = 8'hCA;
   // control register fields
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_MULTIPROC = 5;
   localparam int CTL_RX_EN = 4;
   localparam int CTL_TX9 = 3;
   localparam int CTL_RX9 = 2;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_DONE = 0;
   // power control and interrupt enable fields
   localparam int PWR_RATE_DOUBLE = 7;
   localparam int PWR_FE_SELECT = 6;
   localparam int IE_GLOBAL = 7;
   localparam int IE_SERIAL0 = 4;
   // sticky status fields
   localparam int ST_RX = 0;
   localparam int ST_TX = 1;
   localparam int ST_FE = 2;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // timing in core clocks
   localparam logic [3:0] SYNC_SLOW_DIV = 4'hC;
   localparam logic [3:0] SYNC_FAST_DIV = 4'h4;
   localparam int M2_SLOW_CLKS = 64;
   localparam int M2_FAST_CLKS = 32;
   localparam int OVERSAMPLE = 16;
   localparam logic [2:0] M2_SLOW_LAST = 3'(M2_SLOW_CLKS / OVERSAMPLE - 1);
   localparam logic [2:0] M2_FAST_LAST = 3'(M2_FAST_CLKS / OVERSAMPLE - 1);
   localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] TICK_CENTRE = 4'(OVERSAMPLE / 2 - 1);
   localparam logic [3:0] FRAME10 = 4'hA;
   localparam logic [3:0] FRAME11 = 4'hB;
   localparam logic [3:0] SYNC_BITS_LAST = 4'h7;
   typedef enum logic [1:0] {MODE_SYNC, MODE_ASYNC8, MODE_FIXED9, MODE_ASYNC9} mode_e;
endpackage : sp_pkg

// [verilog/serial_link_if.sv]
`timescale 1ns/1ps
// shared line: device wins a clash, idle line reads high as with a pull-up
interface serial_link_if;
   logic txd;
   logic data_dev_o;
   logic data_dev_oe;
   logic data_rem_o;
   logic data_rem_oe;
   logic data_line;
   assign data_line = data_dev_oe ? data_dev_o : (data_rem_oe ? data_rem_o : 1'b1);
   modport device (output txd, output data_dev_o, output data_dev_oe, input data_line);
   modport remote (input txd, input data_line, output data_rem_o, output data_rem_oe);
endinterface : serial_link_if

// [verilog/serial_port_device.sv]
`timescale 1ns/1ps
module serial_port_device (
   input logic clk_sys,
   input logic rst,
   serial_link_if.device link,
   input logic [7:0] addr,
   input logic [7:0] wdata,
   input logic wr,
   input logic rd,
   output logic [7:0] rdata,
   input logic rate_tick,
   output logic irq
);
   logic mode_hi, mode_lo, multiproc, rx_en, tx9, rx9, tx_done, rx_done, frame_err;
   logic rate_double, fe_select, global_gate, s0_en;
   logic [7:0] rx_buf, slave_addr, slave_mask;
   logic [2:0] status, stat_mask;
   logic [2:0] rx_sync;
   logic rx_f, rx_prev;
   logic [2:0] div_cnt;
   logic sync_busy, sync_is_rx;
   logic [3:0] sync_phase, sync_bits;
   logic [7:0] sync_shift;
   logic tx_busy;
   logic [10:0] tx_shift;
   logic [3:0] tx_bits, tx_ticks;
   logic rx_busy;
   logic [3:0] rx_ticks, rx_idx;
   logic [8:0] rx_sh;
   logic [7:0] next_rdata;
   sp_pkg::mode_e mode;

   assign mode = sp_pkg::mode_e'({mode_hi, mode_lo});
   wire ctl_wr = wr && addr == sp_pkg::ADDR_CONTROL;
   wire buf_wr = wr && addr == sp_pkg::ADDR_BUFFER;
   wire sync_mode = mode == sp_pkg::MODE_SYNC;
   wire nine = mode == sp_pkg::MODE_FIXED9 || mode == sp_pkg::MODE_ASYNC9;

   // pin filter: a level counts once the second and third stages agree
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_sync <= 3'h7;
         rx_f <= 1'b1;
         rx_prev <= 1'b1;
      end
      else
      begin
         rx_sync <= {rx_sync[1:0], link.data_line};
         if (rx_sync[1] == rx_sync[2])
            rx_f <= rx_sync[2];
         rx_prev <= rx_f;
      end
   end

   // fixed rate for mode 2, external rate for modes 1 and 3
   wire [2:0] div_last = rate_double ? sp_pkg::M2_FAST_LAST : sp_pkg::M2_SLOW_LAST;
   always_ff @(posedge clk_sys)
   begin
      if (rst || div_cnt == div_last)
         div_cnt <= 3'h0;
      else
         div_cnt <= div_cnt + 3'h1;
   end
   wire tick16 = (mode == sp_pkg::MODE_FIXED9) ? (div_cnt == div_last) : rate_tick;

   // mode 0 shift engine, shared by send and receive
   wire [3:0] sync_period = multiproc ? sp_pkg::SYNC_FAST_DIV : sp_pkg::SYNC_SLOW_DIV;
   wire tx_start_sync = buf_wr && sync_mode && !sync_busy;
   wire rx_start_sync = sync_mode && rx_en && !rx_done && !sync_busy && !tx_start_sync;
   wire sync_abort = sync_is_rx && !rx_en;
   wire sync_step = sync_busy && !sync_abort && sync_phase == sync_period - 4'h1;
   wire sync_done = sync_step && sync_bits == sp_pkg::SYNC_BITS_LAST;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sync_busy <= 1'b0;
         sync_is_rx <= 1'b0;
         sync_phase <= 4'h0;
         sync_bits <= 4'h0;
         sync_shift <= 8'h00;
      end
      else if (tx_start_sync || rx_start_sync)
      begin
         sync_busy <= 1'b1;
         sync_is_rx <= rx_start_sync;
         sync_phase <= 4'h0;
         sync_bits <= 4'h0;
         sync_shift <= tx_start_sync ? wdata : 8'h00;
      end
      else if (sync_abort)
         sync_busy <= 1'b0;
      else if (sync_step)
      begin
         sync_phase <= 4'h0;
         sync_bits <= sync_bits + 4'h1;
         sync_shift <= {sync_is_rx & rx_f, sync_shift[7:1]};
         if (sync_done)
            sync_busy <= 1'b0;
      end
      else if (sync_busy)
         sync_phase <= sync_phase + 4'h1;
   end

   // async transmitter, frame goes out least significant bit first
   wire tx_start_async = buf_wr && !sync_mode && !tx_busy;
   wire tx_step = tx_busy && tick16 && tx_ticks == sp_pkg::TICK_LAST;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_busy <= 1'b0;
         tx_shift <= 11'h7FF;
         tx_bits <= 4'h0;
         tx_ticks <= 4'h0;
      end
      else if (tx_start_async)
      begin
         tx_busy <= 1'b1;
         tx_ticks <= 4'h0;
         tx_bits <= nine ? sp_pkg::FRAME11 : sp_pkg::FRAME10;
         tx_shift <= nine ? {1'b1, tx9, wdata, 1'b0} : {2'h3, wdata, 1'b0};
      end
      else if (tx_busy && tick16)
      begin
         tx_ticks <= tx_ticks + 4'h1;
         if (tx_step)
         begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits == 4'h1)
               tx_busy <= 1'b0;
         end
      end
   end

   // async receiver: start edge, then each bit taken at its centre
   wire rx_start = !rx_busy && rx_en && !sync_mode && rx_prev && !rx_f;
   wire rx_centre = rx_busy && rx_en && tick16 && rx_ticks == sp_pkg::TICK_CENTRE;
   wire [3:0] rx_last = nine ? sp_pkg::FRAME10 : 4'h9;
   wire rx_finish = rx_centre && rx_idx == rx_last;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_busy <= 1'b0;
         rx_ticks <= 4'h0;
         rx_idx <= 4'h0;
         rx_sh <= 9'h000;
      end
      else if (rx_start)
      begin
         rx_busy <= 1'b1;
         rx_ticks <= 4'h0;
         rx_idx <= 4'h0;
      end
      else if (rx_busy && !rx_en)
         rx_busy <= 1'b0;
      else if (rx_busy && tick16)
      begin
         rx_ticks <= rx_ticks + 4'h1;
         if (rx_centre)
         begin
            // a start bit that is high again at its centre was a glitch
            if ((rx_idx == 4'h0 && rx_f) || rx_finish)
               rx_busy <= 1'b0;
            else
            begin
               rx_idx <= rx_idx + 4'h1;
               if (rx_idx != 4'h0)
                  rx_sh <= {rx_f, rx_sh[8:1]};
            end
         end
      end
   end

   // frame outcome: stop bit, address match, multiprocessor filter
   wire [7:0] rx_byte = nine ? rx_sh[7:0] : rx_sh[8:1];
   wire addr_ok = ((rx_byte ^ slave_addr) & slave_mask) == 8'h00;
   wire accept = nine ? (!multiproc || (rx_sh[8] && addr_ok)) : (!multiproc || rx_f);
   wire ev_fe = rx_finish && !rx_f;
   wire ev_rx_async = rx_finish && accept;
   wire ev_rx = ev_rx_async || (sync_done && sync_is_rx);
   wire ev_tx = (tx_step && tx_bits == 4'h2) || (sync_done && !sync_is_rx);

   // receive register loads only with the flag, so a rejected frame leaves it
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rx_buf <= sp_pkg::REG_RESET;
      else if (ev_rx)
         rx_buf <= sync_mode ? {rx_f, sync_shift[7:1]} : rx_byte;
   end

   // control bits; hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         {mode_hi, mode_lo, multiproc, rx_en, tx9} <= 5'h00;
         {rx9, tx_done, rx_done, frame_err} <= 4'h0;
      end
      else
      begin
         if (ctl_wr)
         begin
            mode_lo <= wdata[sp_pkg::CTL_MODE_LO];
            multiproc <= wdata[sp_pkg::CTL_MULTIPROC];
            rx_en <= wdata[sp_pkg::CTL_RX_EN];
            tx9 <= wdata[sp_pkg::CTL_TX9];
            rx9 <= wdata[sp_pkg::CTL_RX9];
            tx_done <= wdata[sp_pkg::CTL_TX_DONE];
            rx_done <= wdata[sp_pkg::CTL_RX_DONE];
            if (fe_select)
               frame_err <= wdata[sp_pkg::CTL_MODE_HI];
            else
               mode_hi <= wdata[sp_pkg::CTL_MODE_HI];
         end
         if (ev_tx)
            tx_done <= 1'b1;
         if (ev_rx)
            rx_done <= 1'b1;
         if (ev_fe)
            frame_err <= 1'b1;
         if (ev_rx_async && nine)
            rx9 <= rx_sh[8];
         else if (ev_rx_async && !multiproc)
            rx9 <= rx_f;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         {rate_double, fe_select, global_gate, s0_en} <= 4'h0;
         slave_addr <= sp_pkg::REG_RESET;
         slave_mask <= sp_pkg::REG_RESET;
         stat_mask <= sp_pkg::STATUS_RESET;
      end
      else if (wr)
      begin
         if (addr == sp_pkg::ADDR_POWER)
         begin
            rate_double <= wdata[sp_pkg::PWR_RATE_DOUBLE];
            fe_select <= wdata[sp_pkg::PWR_FE_SELECT];
         end
         else if (addr == sp_pkg::ADDR_IRQ_EN)
         begin
            global_gate <= wdata[sp_pkg::IE_GLOBAL];
            s0_en <= wdata[sp_pkg::IE_SERIAL0];
         end
         else if (addr == sp_pkg::ADDR_SLAVE)
            slave_addr <= wdata;
         else if (addr == sp_pkg::ADDR_MASK)
            slave_mask <= wdata;
         else if (addr == sp_pkg::ADDR_STAT_MASK)
            stat_mask <= wdata[2:0];
      end
   end

   // sticky event status, write one to clear, new event wins
   wire [2:0] stat_clr = (wr && addr == sp_pkg::ADDR_STATUS) ? wdata[2:0] : 3'h0;
   wire [2:0] stat_set = {ev_fe, ev_tx, ev_rx};
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         status <= sp_pkg::STATUS_RESET;
      else
         status <= (status & ~stat_clr) | stat_set;
   end

   // read port, data stand one cycle after the strobe
   always_comb
   begin
      next_rdata = 8'h00;
      if (addr == sp_pkg::ADDR_CONTROL)
         next_rdata = {fe_select ? frame_err : mode_hi, mode_lo, multiproc, rx_en,
                       tx9, rx9, tx_done, rx_done};
      else if (addr == sp_pkg::ADDR_BUFFER)
         next_rdata = rx_buf;
      else if (addr == sp_pkg::ADDR_SLAVE)
         next_rdata = slave_addr;
      else if (addr == sp_pkg::ADDR_MASK)
         next_rdata = slave_mask;
      else if (addr == sp_pkg::ADDR_POWER)
      begin
         next_rdata[sp_pkg::PWR_RATE_DOUBLE] = rate_double;
         next_rdata[sp_pkg::PWR_FE_SELECT] = fe_select;
      end
      else if (addr == sp_pkg::ADDR_IRQ_EN)
      begin
         next_rdata[sp_pkg::IE_GLOBAL] = global_gate;
         next_rdata[sp_pkg::IE_SERIAL0] = s0_en;
      end
      else if (addr == sp_pkg::ADDR_STATUS)
         next_rdata = {5'h00, status};
      else if (addr == sp_pkg::ADDR_STAT_MASK)
         next_rdata = {5'h00, stat_mask};
   end
   always_ff @(posedge clk_sys)
   begin
      if (rst || !rd)
         rdata <= 8'h00;
      else
         rdata <= next_rdata;
   end

   // interrupt and line outputs, registered so nothing glitches onto pins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq <= 1'b0;
         link.txd <= 1'b1;
         link.data_dev_o <= 1'b1;
         link.data_dev_oe <= 1'b0;
      end
      else
      begin
         irq <= global_gate & ((s0_en & (tx_done | rx_done)) | (|(status & stat_mask)));
         if (sync_mode)
            link.txd <= !(sync_busy && sync_phase < (sync_period >> 1));
         else
            link.txd <= tx_busy ? tx_shift[0] : 1'b1;
         link.data_dev_o <= sync_shift[0];
         link.data_dev_oe <= sync_busy && !sync_is_rx;
      end
   end
endmodule : serial_port_device

// [verilog/serial_port_remote.sv]
`timescale 1ns/1ps
module serial_port_remote (
   input logic clk_sys,
   input logic rst,
   serial_link_if.remote link,
   input logic [1:0] mode,
   input logic rate_tick,
   input logic send,
   input logic [8:0] send_data,
   output logic busy,
   output logic recv_valid,
   output logic [8:0] recv_data,
   output logic recv_stop_ok
);
   logic [2:0] sync_st [2];
   logic [1:0] filt, prev;
   logic m0_tx, m0_first;
   logic [7:0] m0_sh, m0_rsh;
   logic [3:0] m0_rises, m0_rcnt;
   logic tx_busy;
   logic [10:0] tx_shift;
   logic [3:0] tx_bits, tx_ticks;
   logic rx_busy;
   logic [3:0] rx_ticks, rx_idx;
   logic [8:0] rx_sh;

   wire sync_mode = mode == 2'h0;
   wire nine = mode[1];
   wire [1:0] raw = {link.txd, link.data_line};

   // each pin through three stages, level counts when last two agree
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : pin_filter
         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               sync_st[g] <= 3'h7;
               filt[g] <= 1'b1;
               prev[g] <= 1'b1;
            end
            else
            begin
               sync_st[g] <= {sync_st[g][1:0], raw[g]};
               if (sync_st[g][1] == sync_st[g][2])
                  filt[g] <= sync_st[g][2];
               prev[g] <= filt[g];
            end
         end
      end
   endgenerate
   wire clk_rise = filt[1] && !prev[1];
   wire clk_fall = !filt[1] && prev[1];
   wire line = filt[0];

   // mode 0 slave: sample on rising clock, shift own data on falling
   always_ff @(posedge clk_sys)
   begin
      if (rst || !sync_mode)
      begin
         {m0_tx, m0_first} <= 2'h0;
         {m0_sh, m0_rsh} <= 16'h0000;
         {m0_rises, m0_rcnt} <= 8'h00;
      end
      else if (send && !m0_tx)
      begin
         m0_tx <= 1'b1;
         m0_first <= 1'b1;
         m0_sh <= send_data[7:0];
         m0_rises <= 4'h0;
      end
      else if (m0_tx)
      begin
         if (clk_fall && m0_first)
            m0_first <= 1'b0;
         else if (clk_fall)
            m0_sh <= {1'b1, m0_sh[7:1]};
         if (clk_rise)
         begin
            m0_rises <= m0_rises + 4'h1;
            if (m0_rises == 4'h7)
               m0_tx <= 1'b0;
         end
      end
      else if (clk_rise)
      begin
         m0_rsh <= {line, m0_rsh[7:1]};
         m0_rcnt <= (m0_rcnt == 4'h7) ? 4'h0 : m0_rcnt + 4'h1;
      end
   end
   wire m0_done = sync_mode && !m0_tx && clk_rise && m0_rcnt == 4'h7;

   // async transmitter towards the device
   wire tx_step = tx_busy && rate_tick && tx_ticks == sp_pkg::TICK_LAST;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_busy <= 1'b0;
         tx_shift <= 11'h7FF;
         tx_bits <= 4'h0;
         tx_ticks <= 4'h0;
      end
      else if (send && !sync_mode && !tx_busy)
      begin
         tx_busy <= 1'b1;
         tx_ticks <= 4'h0;
         tx_bits <= nine ? sp_pkg::FRAME11 : sp_pkg::FRAME10;
         tx_shift <= nine ? {1'b1, send_data, 1'b0} : {2'h3, send_data[7:0], 1'b0};
      end
      else if (tx_busy && rate_tick)
      begin
         tx_ticks <= tx_ticks + 4'h1;
         if (tx_step)
         begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits == 4'h1)
               tx_busy <= 1'b0;
         end
      end
   end

   // async receiver from the device transmit line
   wire rx_centre = rx_busy && rate_tick && rx_ticks == sp_pkg::TICK_CENTRE;
   wire rx_finish = rx_centre && rx_idx == (nine ? sp_pkg::FRAME10 : 4'h9);
   always_ff @(posedge clk_sys)
   begin
      if (rst || sync_mode)
      begin
         rx_busy <= 1'b0;
         rx_ticks <= 4'h0;
         rx_idx <= 4'h0;
         rx_sh <= 9'h000;
      end
      else if (!rx_busy && clk_fall)
      begin
         rx_busy <= 1'b1;
         rx_ticks <= 4'h0;
         rx_idx <= 4'h0;
      end
      else if (rx_busy && rate_tick)
      begin
         rx_ticks <= rx_ticks + 4'h1;
         if (rx_centre)
         begin
            if ((rx_idx == 4'h0 && filt[1]) || rx_finish)
               rx_busy <= 1'b0;
            else
            begin
               rx_idx <= rx_idx + 4'h1;
               if (rx_idx != 4'h0)
                  rx_sh <= {filt[1], rx_sh[8:1]};
            end
         end
      end
   end

   // user-side results, registered
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         recv_valid <= 1'b0;
         recv_data <= 9'h000;
         recv_stop_ok <= 1'b0;
         link.data_rem_o <= 1'b1;
         link.data_rem_oe <= 1'b0;
      end
      else
      begin
         recv_valid <= rx_finish || m0_done;
         if (rx_finish)
         begin
            recv_data <= nine ? rx_sh : {1'b0, rx_sh[8:1]};
            recv_stop_ok <= filt[1];
         end
         else if (m0_done)
            recv_data <= {1'b0, line, m0_rsh[7:1]};
         link.data_rem_o <= sync_mode ? m0_sh[0] : (tx_busy ? tx_shift[0] : 1'b1);
         link.data_rem_oe <= sync_mode ? m0_tx : 1'b1;
      end
   end
   assign busy = tx_busy || m0_tx;
endmodule : serial_port_remote

// [bench/serial_link_monitor.sv]
`timescale 1ns/1ps
module serial_link_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic txd,
   input wire logic data_dev_o,
   input wire logic data_dev_oe,
   input wire logic data_rem_o,
   input wire logic data_rem_oe,
   input wire logic data_line
);
   default clocking cb @(posedge clk_sys);
   endclocking
   // reset checks need the reset itself as antecedent, so they carry no disable
   a_reset_txd_idle: assert property (rst |=> txd)
      else $error("txd not idle after reset");
   a_reset_no_drive: assert property (rst |=> !data_dev_oe && !data_rem_oe)
      else $error("data line driven after reset");
   // both ends driving at once would hide a fault behind the interface priority
   a_no_drive_clash: assert property (disable iff (rst) !(data_dev_oe && data_rem_oe))
      else $error("both ends drive the data line");
   // device drive and shift clock come from one register stage, so they start together
   a_device_owns_line: assert property (disable iff (rst)
      $rose(data_dev_oe) |-> $fell(txd))
      else $error("device drive began outside a shift clock low phase");
   // remote lets go after its eighth sampling edge, while the clock is still high
   a_remote_owns_line: assert property (disable iff (rst)
      $fell(data_rem_oe) |-> txd)
      else $error("remote released the line inside a shift clock low phase");
   // shift clock low half lasts 2 or 6 clocks for divide 4 or 12
   a_shift_low_time: assert property (disable iff (rst)
      $fell(txd) && data_dev_oe |-> !txd ##1 !txd ##[1:5] txd)
      else $error("shift clock low phase out of range");
   a_shift_high_hold: assert property (disable iff (rst)
      $rose(txd) && data_dev_oe |-> txd [*2])
      else $error("shift clock high phase too short");
   a_shift_data_stable: assert property (disable iff (rst)
      $rose(txd) && data_dev_oe |-> $stable(data_dev_o))
      else $error("shift data moved at sampling edge");
   c_device_shift: cover property (disable iff (rst) $rose(data_dev_oe));
   c_async_start: cover property (disable iff (rst) $fell(txd) && !data_dev_oe);
   c_remote_start: cover property (disable iff (rst) $fell(data_line) && !data_dev_oe);
endmodule : serial_link_monitor

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] CTL = sp_pkg::ADDR_CONTROL;
   localparam logic [7:0] BUF = sp_pkg::ADDR_BUFFER;
   localparam logic [7:0] STA = sp_pkg::ADDR_STATUS;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic [1:0] cnt = 2'h0;
   logic [1:0] rmode = 2'h1;
   logic rsend = 1'b0;
   logic [8:0] rsdata = 9'h000;
   logic rbusy;
   logic rvalid;
   logic rstop;
   logic [8:0] rrdata;
   logic dtick;
   logic rtick;
   int num_errors = 0;
   int samples_checked = 0;
   serial_link_if link ();
   // async bit is 32 clocks; remote mode 2 needs a quarter-rate tick for 64 clocks
   assign dtick = cnt[0];
   assign rtick = (rmode == 2'h2) ? (cnt == 2'h3) : cnt[0];
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cnt <= cnt + 2'h1;
   serial_port_device serial_port_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rate_tick(dtick),
      .irq(irq));
   serial_port_remote serial_port_remote_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
      .mode(rmode), .rate_tick(rtick), .send(rsend), .send_data(rsdata), .busy(rbusy),
      .recv_valid(rvalid), .recv_data(rrdata), .recv_stop_ok(rstop));
   serial_link_monitor serial_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
      .txd(link.txd), .data_dev_o(link.data_dev_o), .data_dev_oe(link.data_dev_oe),
      .data_rem_o(link.data_rem_o), .data_rem_oe(link.data_rem_oe),
      .data_line(link.data_line));
   task automatic conclude();
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      check({1'b0, rdata}, {1'b0, exp});
   endtask : rd_chk
   // irq is registered behind the register write, so give it a few clocks
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clk_sys);
      #1;
      check({8'h00, irq}, {8'h00, exp});
   endtask : irq_is
   // bounded wait for the remote frame to end, then room for the device flag
   task automatic send_rem(input logic [8:0] d);
      int i;
      @(posedge clk_sys);
      rsend <= 1'b1;
      rsdata <= d;
      @(posedge clk_sys);
      rsend <= 1'b0;
      for (i = 0; i < 2000 && (i < 2 || rbusy !== 1'b0); i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check({8'h00, rbusy}, 9'h000);
      repeat (40) @(posedge clk_sys);
   endtask : send_rem
   initial
   begin
      #400000;
      num_errors++;
      conclude();
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(CTL, sp_pkg::REG_RESET);
      rd_chk(8'h55, 8'h00);
      wr_reg(sp_pkg::ADDR_SLAVE, 8'h12);
      rd_chk(sp_pkg::ADDR_SLAVE, 8'h12);
      wr_reg(sp_pkg::ADDR_MASK, 8'hFF);
      rd_chk(sp_pkg::ADDR_MASK, 8'hFF);
      // mode 1 send: flag before 8 bits is clear, after 9 bits set
      wr_reg(sp_pkg::ADDR_IRQ_EN, 8'h80);
      wr_reg(CTL, 8'h40);
      wr_reg(BUF, 8'hA5);
      repeat (245) @(posedge clk_sys);
      rd_chk(CTL, 8'h40);
      repeat (50) @(posedge clk_sys);
      rd_chk(CTL, 8'h42);
      repeat (60) @(posedge clk_sys);
      check(rrdata, 9'h0A5);
      check({8'h00, irq}, 9'h000);
      rd_chk(STA, 8'h02);
      wr_reg(sp_pkg::ADDR_STAT_MASK, 8'h02);
      irq_is(1'b1);
      wr_reg(STA, 8'h02);
      irq_is(1'b0);
      wr_reg(sp_pkg::ADDR_IRQ_EN, 8'h90);
      irq_is(1'b1);
      wr_reg(CTL, 8'h40);
      irq_is(1'b0);
      // receive disabled, then enabled: stop bit lands in the ninth-bit field
      send_rem(9'h081);
      rd_chk(CTL, 8'h40);
      wr_reg(CTL, 8'h50);
      send_rem(9'h03C);
      rd_chk(CTL, 8'h55);
      rd_chk(BUF, 8'h3C);
      irq_is(1'b1);
      // mode 3 with address match: wrong address, ninth zero, then a hit
      @(posedge clk_sys);
      rmode <= 2'h3;
      wr_reg(CTL, 8'hF0);
      send_rem(9'h134);
      rd_chk(CTL, 8'hF0);
      send_rem(9'h012);
      rd_chk(CTL, 8'hF0);
      send_rem(9'h112);
      rd_chk(CTL, 8'hF5);
      rd_chk(BUF, 8'h12);
      wr_reg(sp_pkg::ADDR_MASK, 8'h00);
      wr_reg(CTL, 8'hF0);
      send_rem(9'h177);
      rd_chk(BUF, 8'h77);
      // mode 1 device fed 11-bit frames: a zero ninth bit lands on its stop sample
      wr_reg(CTL, 8'h54);
      wr_reg(sp_pkg::ADDR_POWER, 8'h40);
      send_rem(9'h0A6);
      rd_chk(CTL, 8'hD1);
      rd_chk(STA, 8'h05);
      wr_reg(CTL, 8'h70);
      send_rem(9'h0A6);
      rd_chk(CTL, 8'hF0);
      wr_reg(CTL, 8'h70);
      rd_chk(CTL, 8'h70);
      wr_reg(sp_pkg::ADDR_POWER, 8'h00);
      // mode 2 at 64 clocks a bit, software ninth bit set
      @(posedge clk_sys);
      rmode <= 2'h2;
      wr_reg(CTL, 8'h88);
      wr_reg(BUF, 8'h5A);
      repeat (600) @(posedge clk_sys);
      rd_chk(CTL, 8'h88);
      repeat (60) @(posedge clk_sys);
      rd_chk(CTL, 8'h8A);
      repeat (100) @(posedge clk_sys);
      check(rrdata, 9'h15A);
      // mode 0 shift out at divide 12
      @(posedge clk_sys);
      rmode <= 2'h0;
      wr_reg(CTL, 8'h00);
      wr_reg(BUF, 8'hE1);
      repeat (82) @(posedge clk_sys);
      rd_chk(CTL, 8'h00);
      repeat (18) @(posedge clk_sys);
      rd_chk(CTL, 8'h02);
      repeat (10) @(posedge clk_sys);
      check(rrdata, 9'h0E1);
      // mode 0 receive: remote primed first, device clocks it in once enabled; then shift out at divide 4
      @(posedge clk_sys);
      rsend <= 1'b1;
      rsdata <= 9'h0C3;
      @(posedge clk_sys);
      rsend <= 1'b0;
      wr_reg(CTL, 8'h10);
      repeat (110) @(posedge clk_sys);
      rd_chk(CTL, 8'h11);
      rd_chk(BUF, 8'hC3);
      check({8'h00, rbusy}, 9'h000);
      wr_reg(CTL, 8'h20);
      wr_reg(BUF, 8'h3C);
      repeat (22) @(posedge clk_sys);
      rd_chk(CTL, 8'h20);
      repeat (10) @(posedge clk_sys);
      rd_chk(CTL, 8'h22);
      repeat (5) @(posedge clk_sys);
      check(rrdata, 9'h03C);
      conclude();
   end
endmodule : tb
